// ==== rtl/cid_pkg.sv ====
package cid_pkg;

  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int FILE_AW = 7;
  localparam int DATA_W  = 8;
  localparam int JUMP_W  = 11;

  // opcode and destination bit positions inside an instruction word
  localparam int DEST_BIT    = 7;
  localparam int OPC_HI      = 13;
  localparam int OPC_LO      = 8;
  localparam int JUMP_OPC_LO = 11;

  // high latch bits that feed program counter bits 12:11
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  // opcode patterns; bits 13:8, jump uses bits 13:11
  localparam logic [5:0] OPC_CLEAR = 6'h01;
  localparam logic [5:0] OPC_DEC   = 6'h03;
  localparam logic [5:0] OPC_INV   = 6'h09;
  localparam logic [5:0] OPC_INC   = 6'h0A;
  localparam logic [5:0] OPC_DSKIP = 6'h0B;
  localparam logic [2:0] OPC_JUMP  = 3'h5;

  localparam logic [PC_W-1:0]    PC_RESET   = 13'h0000;
  localparam logic [PC_W-1:0]    PC_STEP    = 13'h0001;
  localparam logic [PC_W-1:0]    PC_SKIP    = 13'h0002;
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0]  DATA_ONE   = 8'h01;
  localparam logic [INSTR_W-1:0] INSTR_NOP  = 14'h0000;
  localparam logic               ZERO_RESET = 1'b0;

  typedef enum logic [2:0] {
    OP_NOP        = 3'b000,
    OP_CLEAR_FILE = 3'b001,
    OP_CLEAR_ACC  = 3'b010,
    OP_DECREMENT  = 3'b011,
    OP_DEC_SKIP   = 3'b100,
    OP_INCREMENT  = 3'b101,
    OP_INVERT     = 3'b110,
    OP_JUMP       = 3'b111
  } cid_op_t;

  // one instruction cycle is three core clocks
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_READ  = 2'b01,
    ST_EXEC  = 2'b10
  } cid_state_t;

  function automatic cid_op_t decode_op(input logic [INSTR_W-1:0] w);
    cid_op_t op;
    op = OP_NOP;
    if (w[OPC_HI:JUMP_OPC_LO] == OPC_JUMP)
    begin
      op = OP_JUMP;
    end
    else
    begin
      case (w[OPC_HI:OPC_LO])
        OPC_CLEAR: op = w[DEST_BIT] ? OP_CLEAR_FILE : OP_CLEAR_ACC;
        OPC_DEC:   op = OP_DECREMENT;
        OPC_DSKIP: op = OP_DEC_SKIP;
        OPC_INC:   op = OP_INCREMENT;
        OPC_INV:   op = OP_INVERT;
        default:   op = OP_NOP;
      endcase
    end
    return op;
  endfunction

endpackage

// ==== rtl/cid_file_mem.sv ====
`timescale 1ns/1ps
module cid_file_mem (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic                           wrEn,
  input  wire logic [cid_pkg::FILE_AW-1:0]    wrAddr,
  input  wire logic [cid_pkg::DATA_W-1:0]     wrData,
  input  wire logic [cid_pkg::FILE_AW-1:0]    rdAddr,
  output logic      [cid_pkg::DATA_W-1:0]     rdData
);

  logic [cid_pkg::DATA_W-1:0] mem [2**cid_pkg::FILE_AW];
  logic [cid_pkg::DATA_W-1:0] rdData_q;

  // array left unreset so it maps onto plain storage
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    if (rst)
    begin
      rdData_q <= cid_pkg::DATA_ZERO;
    end
    else
    begin
      rdData_q <= mem[rdAddr];
    end
  end

  assign rdData = rdData_q;

endmodule // cid_file_mem

// ==== rtl/cid_alu.sv ====
`timescale 1ns/1ps
module cid_alu (
  input  wire cid_pkg::cid_op_t               op,
  input  wire logic [cid_pkg::DATA_W-1:0]     operand,
  output logic      [cid_pkg::DATA_W-1:0]     result,
  output logic                                zero
);

  always_comb
  begin
    case (op)
      cid_pkg::OP_CLEAR_FILE: result = cid_pkg::DATA_ZERO;
      cid_pkg::OP_CLEAR_ACC:  result = cid_pkg::DATA_ZERO;
      cid_pkg::OP_DECREMENT:  result = operand - cid_pkg::DATA_ONE;
      cid_pkg::OP_DEC_SKIP:   result = operand - cid_pkg::DATA_ONE;
      cid_pkg::OP_INCREMENT:  result = operand + cid_pkg::DATA_ONE;
      cid_pkg::OP_INVERT:     result = ~operand;
      default:                result = operand;
    endcase
    zero = (result == cid_pkg::DATA_ZERO);
  end

endmodule // cid_alu

// ==== rtl/cid_core.sv ====
// Summary of operation
// (RL1) clear file: register gets zero, zero flag set
// (RL2) clear accumulator: accumulator zero, zero flag set
// (RL3) decrement file, destination bit routes, zero updated
// (RL4) decrement-skip routes result, flags left unchanged
// (RL5) zero result discards next instruction as nop
// (RL6) jump loads 11-bit operand into counter 10:0
// (RL7) counter 12:11 come from high latch 4:3
// (RL8) jump takes two instruction cycles
// (RL9) increment file, destination bit routes, zero updated
// (RL10) invert file, destination bit routes result
// (RL11) zero flag set exactly when result zero; decrement-skip leaves the flag unchanged instead
`timescale 1ns/1ps
module cid_core (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic [cid_pkg::INSTR_W-1:0]    progData,
  input  wire logic [cid_pkg::DATA_W-1:0]     counterHighLatch,
  output logic      [cid_pkg::PC_W-1:0]       progAddr,
  output logic      [cid_pkg::DATA_W-1:0]     accumulator,
  output logic                                zeroFlag,
  output logic                                fileWrEn,
  output logic      [cid_pkg::FILE_AW-1:0]    fileWrAddr,
  output logic      [cid_pkg::DATA_W-1:0]     fileWrData,
  output logic                                nopCycle
);

  cid_pkg::cid_state_t                 state_q;
  cid_pkg::cid_state_t                 state_d;
  logic [cid_pkg::INSTR_W-1:0]         instr_q;
  logic [cid_pkg::INSTR_W-1:0]         instr_d;
  logic [cid_pkg::PC_W-1:0]            pc_q;
  logic [cid_pkg::PC_W-1:0]            pc_d;
  logic [cid_pkg::DATA_W-1:0]          acc_q;
  logic [cid_pkg::DATA_W-1:0]          acc_d;
  logic                                zero_q;
  logic                                zero_d;
  logic                                bubble_q;
  logic                                bubble_d;
  logic                                wrEn_q;
  logic                                wrEn_d;
  logic [cid_pkg::FILE_AW-1:0]         wrAddr_q;
  logic [cid_pkg::FILE_AW-1:0]         wrAddr_d;
  logic [cid_pkg::DATA_W-1:0]          wrData_q;
  logic [cid_pkg::DATA_W-1:0]          wrData_d;

  cid_pkg::cid_op_t                    op;
  logic [cid_pkg::DATA_W-1:0]          memRdData;
  logic [cid_pkg::DATA_W-1:0]          aluResult;
  logic                                aluZero;
  logic                                execLive;
  logic                                destFile;

  assign op       = cid_pkg::decode_op(instr_q);
  assign execLive = (state_q == cid_pkg::ST_EXEC) && !bubble_q;
  assign destFile = instr_q[cid_pkg::DEST_BIT];

  // read issued in the read phase lands for the execute phase
  cid_file_mem u_file_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .wrEn     (wrEn_q),
    .wrAddr   (wrAddr_q),
    .wrData   (wrData_q),
    .rdAddr   (instr_q[cid_pkg::FILE_AW-1:0]),
    .rdData   (memRdData)
  );

  cid_alu u_alu (
    .op      (op),
    .operand (memRdData),
    .result  (aluResult),
    .zero    (aluZero)
  );

  always_comb
  begin
    state_d  = state_q;
    instr_d  = instr_q;
    pc_d     = pc_q;
    acc_d    = acc_q;
    zero_d   = zero_q;
    bubble_d = bubble_q;
    wrEn_d   = 1'b0;
    wrAddr_d = instr_q[cid_pkg::FILE_AW-1:0];
    wrData_d = aluResult;
    case (state_q)
      cid_pkg::ST_FETCH:
      begin
        instr_d = progData;
        state_d = cid_pkg::ST_READ;
      end
      cid_pkg::ST_READ:
      begin
        state_d = cid_pkg::ST_EXEC;
      end
      cid_pkg::ST_EXEC:
      begin
        state_d = cid_pkg::ST_FETCH;
        if (bubble_q)
        begin
          // counter already points past the discarded word
          bubble_d = 1'b0;
        end
        else
        begin
          pc_d = pc_q + cid_pkg::PC_STEP;
          case (op)
            cid_pkg::OP_CLEAR_FILE:
            begin
              wrEn_d = 1'b1; // [RL1]
              zero_d = 1'b1; // [RL1]
            end
            cid_pkg::OP_CLEAR_ACC:
            begin
              acc_d  = cid_pkg::DATA_ZERO; // [RL2]
              zero_d = 1'b1; // [RL2]
            end
            cid_pkg::OP_DECREMENT,
            cid_pkg::OP_INCREMENT,
            cid_pkg::OP_INVERT:
            begin
              wrEn_d = destFile; // [RL3] [RL9] [RL10]
              if (!destFile)
              begin
                acc_d = aluResult; // [RL3] [RL9] [RL10]
              end
              zero_d = aluZero; // [RL11]
            end
            cid_pkg::OP_DEC_SKIP:
            begin
              // status left alone on purpose
              wrEn_d = destFile; // [RL4]
              if (!destFile)
              begin
                acc_d = aluResult; // [RL4]
              end
              if (aluZero)
              begin
                // skip the next word and spend a dead cycle on it
                pc_d     = pc_q + cid_pkg::PC_SKIP; // [RL5]
                bubble_d = 1'b1; // [RL5]
              end
            end
            cid_pkg::OP_JUMP:
            begin
              pc_d = {counterHighLatch[cid_pkg::LATCH_HI:cid_pkg::LATCH_LO],
                      instr_q[cid_pkg::JUMP_W-1:0]}; // [RL6] [RL7]
              bubble_d = 1'b1; // [RL8]
            end
            default:
            begin
              pc_d = pc_q + cid_pkg::PC_STEP;
            end
          endcase
        end
      end
      default:
      begin
        state_d = cid_pkg::ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q  <= cid_pkg::ST_FETCH;
      instr_q  <= cid_pkg::INSTR_NOP;
      pc_q     <= cid_pkg::PC_RESET;
      acc_q    <= cid_pkg::DATA_ZERO;
      zero_q   <= cid_pkg::ZERO_RESET;
      bubble_q <= 1'b0;
      wrEn_q   <= 1'b0;
      wrAddr_q <= '0;
      wrData_q <= cid_pkg::DATA_ZERO;
    end
    else
    begin
      state_q  <= state_d;
      instr_q  <= instr_d;
      pc_q     <= pc_d;
      acc_q    <= acc_d;
      zero_q   <= zero_d;
      bubble_q <= bubble_d;
      wrEn_q   <= wrEn_d;
      wrAddr_q <= wrAddr_d;
      wrData_q <= wrData_d;
    end
  end

  assign progAddr    = pc_q;
  assign accumulator = acc_q;
  assign zeroFlag    = zero_q;
  assign fileWrEn    = wrEn_q;
  assign fileWrAddr  = wrAddr_q;
  assign fileWrData  = wrData_q;
  assign nopCycle    = bubble_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_jump_exec;
    execLive && op == cid_pkg::OP_JUMP;
  endsequence

  // a decrement-skip's own write lands in the first dead clock,
  // so only the clock after the dead cycle must stay quiet
  sequence s_dead_cycle;
    nopCycle [*3] ##1 (!nopCycle && !fileWrEn);
  endsequence

  a_clear_file_zero: assert property ( // [RL1]
    execLive && op == cid_pkg::OP_CLEAR_FILE |=> fileWrEn && zeroFlag
      && fileWrData == 8'h00 && fileWrAddr == $past(instr_q[6:0]))
    else $error("clear file did not zero register and set flag");

  a_clear_acc_zero: assert property ( // [RL2]
    execLive && op == cid_pkg::OP_CLEAR_ACC |=>
      accumulator == 8'h00 && zeroFlag && !fileWrEn)
    else $error("clear accumulator did not zero and set flag");

  a_dec_route_file: assert property ( // [RL3]
    execLive && op == cid_pkg::OP_DECREMENT && destFile |=>
      fileWrEn && (fileWrData + 8'h01) == $past(memRdData)
      && accumulator == $past(acc_q))
    else $error("decrement to file routed wrongly");

  a_dec_route_acc: assert property ( // [RL3]
    execLive && op == cid_pkg::OP_DECREMENT && !destFile |=>
      !fileWrEn && (accumulator + 8'h01) == $past(memRdData))
    else $error("decrement to accumulator routed wrongly");

  a_dskip_flag_hold: assert property ( // [RL4]
    execLive && op == cid_pkg::OP_DEC_SKIP |=> $stable(zeroFlag))
    else $error("decrement skip changed the zero flag");

  a_dskip_skip_zero: assert property ( // [RL5]
    execLive && op == cid_pkg::OP_DEC_SKIP && memRdData == 8'h01 |=>
      progAddr == $past(pc_q) + 13'h0002 ##0 s_dead_cycle)
    else $error("zero result did not discard next instruction");

  a_dskip_no_skip: assert property ( // [RL5]
    execLive && op == cid_pkg::OP_DEC_SKIP && memRdData != 8'h01 |=>
      !nopCycle && progAddr == $past(pc_q) + 13'h0001)
    else $error("nonzero result skipped an instruction");

  a_jump_low_bits: assert property ( // [RL6]
    s_jump_exec |=> progAddr[10:0] == $past(instr_q[10:0]))
    else $error("jump target low bits wrong");

  a_jump_high_bits: assert property ( // [RL7]
    s_jump_exec |=> progAddr[12:11] == $past(counterHighLatch[4:3]))
    else $error("jump target high bits not from latch");

  a_jump_two_cycle: assert property ( // [RL8]
    s_jump_exec |=> s_dead_cycle ##0 $stable(progAddr))
    else $error("jump did not spend one dead instruction cycle");

  a_jump_flag_hold: assert property ( // [RL6]
    s_jump_exec |=> $stable(zeroFlag) && $stable(accumulator) && !fileWrEn)
    else $error("jump changed status, accumulator or a register");

  a_dead_no_effect: assert property ( // [RL5] [RL8]
    state_q == cid_pkg::ST_EXEC && bubble_q |=> !fileWrEn
      && $stable(accumulator) && $stable(zeroFlag) && $stable(progAddr))
    else $error("discarded instruction took effect");

  a_clear_file_keep: assert property ( // [RL1]
    execLive && op == cid_pkg::OP_CLEAR_FILE |=>
      accumulator == $past(acc_q) && progAddr == $past(pc_q) + 13'h0001)
    else $error("clear file disturbed accumulator or counter");

  a_dec_zero_flag: assert property ( // [RL3] [RL11]
    execLive && op == cid_pkg::OP_DECREMENT |=>
      zeroFlag == ($past(memRdData) == 8'h01))
    else $error("decrement zero flag wrong");

  a_inc_route_file: assert property ( // [RL9]
    execLive && op == cid_pkg::OP_INCREMENT && destFile |=>
      fileWrEn && fileWrData == $past(memRdData) + 8'h01
      && accumulator == $past(acc_q))
    else $error("increment to file routed wrongly");

  a_inc_route_acc: assert property ( // [RL9]
    execLive && op == cid_pkg::OP_INCREMENT && !destFile |=>
      !fileWrEn && accumulator == $past(memRdData) + 8'h01)
    else $error("increment to accumulator routed wrongly");

  a_invert_zero_flag: assert property ( // [RL11]
    execLive && op == cid_pkg::OP_INVERT |=>
      zeroFlag == ($past(memRdData) == 8'hFF))
    else $error("invert zero flag wrong");

  a_dskip_route: assert property ( // [RL4]
    execLive && op == cid_pkg::OP_DEC_SKIP |=>
      fileWrEn == $past(destFile)
      && ((destFile ? fileWrData : accumulator) + 8'h01) == $past(memRdData))
    else $error("decrement skip routed wrongly");

  a_inc_zero_flag: assert property ( // [RL9] [RL11]
    execLive && op == cid_pkg::OP_INCREMENT |=>
      zeroFlag == ($past(memRdData) == 8'hFF))
    else $error("increment zero flag wrong");

  a_invert_route: assert property ( // [RL10]
    execLive && op == cid_pkg::OP_INVERT |=>
      (destFile ? fileWrData : accumulator) == ~$past(memRdData)
      && fileWrEn == $past(destFile))
    else $error("invert result routed wrongly");

endmodule // cid_core

// ==== testbench/cid_prog_mem_model.sv ====
`timescale 1ns/1ps
module cid_prog_mem_model (
  input  wire logic [cid_pkg::PC_W-1:0]    progAddr,
  output logic      [cid_pkg::INSTR_W-1:0] progData
);
  // read is combinational so the word holds for the whole fetch clock
  logic [cid_pkg::INSTR_W-1:0] mem [0:(1<<cid_pkg::PC_W)-1];

  assign progData = mem[progAddr];
endmodule // cid_prog_mem_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic                          core_clk = 1'b0;
  logic                          rst      = 1'b1;
  logic [cid_pkg::INSTR_W-1:0]   progData;
  logic [cid_pkg::DATA_W-1:0]    hiLatch  = 8'hF7;
  logic [cid_pkg::DATA_W-1:0]    nextLatch = 8'hF7;
  logic [cid_pkg::PC_W-1:0]      progAddr;
  logic [cid_pkg::DATA_W-1:0]    accumulator;
  logic                          zeroFlag;
  logic                          fileWrEn;
  logic [cid_pkg::FILE_AW-1:0]   fileWrAddr;
  logic [cid_pkg::DATA_W-1:0]    fileWrData;
  logic                          nopCycle;
  int                            error_cnt = 0;
  int                            compares  = 0;
  int                            cycles    = 0;

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) hiLatch <= nextLatch;

  cid_core dut (
    .core_clk(core_clk), .rst(rst), .progData(progData),
    .counterHighLatch(hiLatch), .progAddr(progAddr),
    .accumulator(accumulator), .zeroFlag(zeroFlag), .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .nopCycle(nopCycle)
  );

  cid_prog_mem_model pmem (.progAddr(progAddr), .progData(progData));

  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hang of the sequencer is cut short here
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 500)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one instruction cycle later, look at what the executed word left behind
  task automatic ex(input logic [12:0] pa, input logic [7:0] ac,
                    input logic z, input logic we, input logic [6:0] wa,
                    input logic [7:0] wd, input logic nop);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk({8'h00, progAddr, accumulator, zeroFlag, fileWrEn, nopCycle},
        {8'h00, pa, ac, z, we, nop});
    if (we)
      chk({17'h00000, fileWrAddr, fileWrData}, {17'h00000, wa, wd});
  endtask

  task automatic t_basic();
    ex(13'h0001, 8'h00, 1'b1, 1'b1, 7'h05, 8'h00, 1'b0);
    ex(13'h0002, 8'h00, 1'b0, 1'b1, 7'h05, 8'h01, 1'b0);
    ex(13'h0003, 8'h02, 1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
    ex(13'h0004, 8'h02, 1'b1, 1'b1, 7'h05, 8'h00, 1'b0);
    ex(13'h0005, 8'hFF, 1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
    ex(13'h0006, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00, 1'b0);
    ex(13'h0007, 8'h00, 1'b0, 1'b1, 7'h05, 8'hFF, 1'b0);
    ex(13'h0008, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00, 1'b0);
  endtask

  // zero flag is left set going in, so an unwanted update shows
  task automatic t_skip();
    ex(13'h0009, 8'h00, 1'b1, 1'b1, 7'h05, 8'hFE, 1'b0);
    ex(13'h000A, 8'hFD, 1'b1, 1'b0, 7'h00, 8'h00, 1'b0);
    ex(13'h000B, 8'hFD, 1'b1, 1'b1, 7'h06, 8'h00, 1'b0);
    ex(13'h000C, 8'hFD, 1'b0, 1'b1, 7'h06, 8'h01, 1'b0);
    ex(13'h000E, 8'h00, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1);
    ex(13'h000E, 8'h00, 1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
  endtask

  // the word after each jump would change the accumulator if run
  task automatic t_jump();
    ex(13'h17FF, 8'h00, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1);
    ex(13'h17FF, 8'h00, 1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
    nextLatch = 8'h08;
    ex(13'h1800, 8'h00, 1'b0, 1'b1, 7'h06, 8'h02, 1'b0);
    ex(13'h0805, 8'h00, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1);
    ex(13'h0805, 8'h00, 1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
    ex(13'h0806, 8'h00, 1'b1, 1'b1, 7'h07, 8'h00, 1'b0);
  endtask

  // zero result routed to the file: the write still lands, then the skip
  task automatic t_skip_write();
    ex(13'h0807, 8'h00, 1'b0, 1'b1, 7'h07, 8'h01, 1'b0);
    ex(13'h0809, 8'h00, 1'b0, 1'b1, 7'h07, 8'h00, 1'b1);
    ex(13'h0809, 8'h00, 1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
  endtask

  initial
  begin
    logic [13:0] prog [0:15];
    prog = '{14'h0185, 14'h0A85, 14'h0A05, 14'h0385, 14'h0305, 14'h0100,
             14'h0985, 14'h0905, 14'h0B85, 14'h0B05, 14'h0186, 14'h0A86,
             14'h0B06, 14'h0A05, 14'h2FFF, 14'h0A05};
    for (int i = 0; i < 8192; i++)
      pmem.mem[i] = 14'h0000;
    for (int i = 0; i < 16; i++)
      pmem.mem[i] = prog[i];
    pmem.mem[13'h17FF] = 14'h0A86;
    pmem.mem[13'h1800] = 14'h2805;
    pmem.mem[13'h1801] = 14'h0A05;
    pmem.mem[13'h0805] = 14'h0187;
    pmem.mem[13'h0806] = 14'h0A87;
    pmem.mem[13'h0807] = 14'h0B87;
    pmem.mem[13'h0808] = 14'h0A05;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_basic();
    t_skip();
    t_jump();
    t_skip_write();
    finish_test();
  end
endmodule // tb
